// ### hdl/vpi_ctrl.sv
// Vectored priority interrupt controller: flags, enables, priorities,
// winner selection, vector/level latch and current processor level.
// Assumes request pulses from same-clock peripherals, one external pin,
// and a core that acknowledges and returns with single-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Thirty-seven registers: two global, six flag, six enable, 22 priority, one latch.
// - Global control one holds nesting disable and the trap status flags.
// - Global control two sets external edge polarity and alternate table select.
// - Each source has a flag set by hardware and cleared only by software.
// - Each source has an enable; a disabled source never requests service.
// - Three-bit priority per source; seven highest, one lowest, zero disables.
// - Winning vector latched in seven bits, new level in four bits.
// - The latched new level equals the winner's programmed priority.
// - Flag, enable and priority bits follow ascending vector number.
// - Vector number is natural order; external request zero is vector zero.
// - Timer 1 uses vector 3, entries 1Ah and 11Ah.
// - Timer 4 uses vector 27, entries 4Ah and 14Ah.
// - UART 3 error, receive, transmit use vectors 81, 82, 83.
// - USB uses vector 86, entries C0h and 1C0h.
// - Status register bits 7:5 show and set the low three level bits.
// - Top level bit is read-only so traps stay unmaskable.
// - Timer 4 / compare priority register fields reset to 100; rest read zero.
// - UART 3 priority register fields reset to 100; bits 15,11,7,3:0 zero.
module vpi_ctrl
  import vpi_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          sys_rst,
  // Register port
  input  wire logic [vpi_pkg::ADDR_W-1:0]    reg_addr,
  input  wire logic [vpi_pkg::DATA_W-1:0]    reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output logic      [vpi_pkg::DATA_W-1:0]    reg_rdata,
  // Request sources
  input  wire logic [vpi_pkg::NUM_SRC-1:0]   src_req,
  input  wire logic                          ext0_pin,
  input  wire logic [vpi_pkg::NUM_TRAPS-1:0] trap_evt,
  // Core side
  output logic                               irq_req,
  output logic      [vpi_pkg::VEC_W-1:0]     irq_vector,
  output logic      [vpi_pkg::LVL_W-1:0]     irq_level,
  output logic      [vpi_pkg::VADDR_W-1:0]   irq_addr,
  input  wire logic                          irq_ack,
  input  wire logic                          irq_return,
  input  wire logic [vpi_pkg::LVL_W-1:0]     ret_level,
  output logic      [vpi_pkg::LVL_W-1:0]     cpu_level
);
  import vpi_pkg::*;

  // ==========================================================================
  // Helpers

  // Priority field of one source, zero where the field does not exist
  function automatic logic [PRIO_W-1:0] prio_of(
    input logic [NUM_SRC*PRIO_W-1:0] prios,
    input int unsigned               v
  );
    logic [PRIO_W-1:0] p;
    p = prios[v*PRIO_W +: PRIO_W];
    prio_of = SRC_IMPL[v] ? p : PRIO_OFF;
  endfunction : prio_of

  // Entry address: two bytes per vector above the table base
  function automatic logic [VADDR_W-1:0] vec_addr(
    input logic [VEC_W-1:0] v,
    input logic             alt
  );
    logic [VADDR_W-1:0] a;
    a = IVT_BASE + {{(VADDR_W-VEC_W-1){1'b0}}, v, 1'b0};
    vec_addr = alt ? (a + ALTERNATE_VECTOR_TABLE_OFFSET) : a;
  endfunction : vec_addr

  // ==========================================================================
  // State
  vpi_state_s s_q;
  vpi_state_s s_d;

  logic                ext0_edge;
  logic [NUM_SRC-1:0]  hw_set;
  logic [PRIO_W-1:0]   best_prio;
  logic [VEC_W-1:0]    best_vec;
  logic                blocked;
  logic [DATA_W-1:0]   rd_val;

  // Edge of the external pin after synchronising, polarity chosen by software
  assign ext0_edge = s_q.ext0_neg_edge ? (s_q.ext0_prev & ~s_q.ext0_sync)
                                       : (~s_q.ext0_prev & s_q.ext0_sync);

  // Hardware sets; external request zero lands on vector zero
  assign hw_set = src_req | {{(NUM_SRC-1){1'b0}}, ext0_edge};

  // Winner search; scanning downward with >= leaves the lowest vector on ties
  always_comb
  begin
    best_prio = PRIO_OFF;
    best_vec  = '0;
    for (int unsigned i = NUM_SRC; i > 0; i--)
    begin
      if (s_q.flags[i-1] && s_q.enables[i-1] && SRC_IMPL[i-1]
          && (prio_of(s_q.prios, i-1) != PRIO_OFF)
          && ({1'b0, prio_of(s_q.prios, i-1)} > s_q.cpu_level)
          && (prio_of(s_q.prios, i-1) >= best_prio))
      begin
        best_prio = prio_of(s_q.prios, i-1);
        best_vec  = VEC_W'(i-1);
      end
    end
  end

  // No preemption while nesting is off and a handler runs
  assign blocked = s_q.nest_dis && (s_q.depth != '0);

  // ==========================================================================
  // Read mux; decode by index, unmapped and gap registers read zero
  always_comb
  begin
    rd_val = '0;
    if (reg_addr == IDX_GCTRL1)
    begin
      rd_val[GC1_NEST_BIT] = s_q.nest_dis;
      rd_val[GC1_TRAP_LSB +: NUM_TRAPS] = s_q.trap_flags;
    end
    else if (reg_addr == IDX_GCTRL2)
    begin
      rd_val[GC2_ALT_BIT]  = s_q.alt_table;
      rd_val[GC2_EDGE_BIT] = s_q.ext0_neg_edge;
    end
    else if (reg_addr >= IDX_FLAG0 && reg_addr < IDX_FLAG0 + ADDR_W'(NUM_FREGS))
    begin
      rd_val = s_q.flags[(reg_addr - IDX_FLAG0)*DATA_W +: DATA_W]
             & SRC_IMPL[(reg_addr - IDX_FLAG0)*DATA_W +: DATA_W];
    end
    else if (reg_addr >= IDX_EN0 && reg_addr < IDX_EN0 + ADDR_W'(NUM_FREGS))
    begin
      rd_val = s_q.enables[(reg_addr - IDX_EN0)*DATA_W +: DATA_W]
             & SRC_IMPL[(reg_addr - IDX_EN0)*DATA_W +: DATA_W];
    end
    else if (reg_addr >= IDX_PRIO0 && reg_addr < IDX_PRIO0 + ADDR_W'(NUM_PREGS))
    begin
      // Field k of register r sits at bits 4k+2:4k; bit 4k+3 reads zero
      for (int unsigned k = 0; k < FLD_PER_PR; k++)
      begin
        rd_val[k*4 +: PRIO_W] =
          prio_of(s_q.prios, (reg_addr - IDX_PRIO0)*FLD_PER_PR + k);
      end
    end
    else if (reg_addr == IDX_LATCH)
    begin
      rd_val[LATCH_VEC_LSB +: VEC_W] = s_q.vec;
      rd_val[LATCH_LVL_LSB +: LVL_W] = s_q.lvl;
    end
    else if (reg_addr == IDX_STATUS)
    begin
      rd_val[SR_IPL_LSB +: PRIO_W] = s_q.cpu_level[PRIO_W-1:0];
    end
    else if (reg_addr == IDX_CORE)
    begin
      rd_val[CORE_TOP_BIT] = s_q.cpu_level[LVL_W-1];
    end
  end

  // ==========================================================================
  // Next state
  always_comb
  begin
    s_d = s_q;

    // Two-flop synchroniser, then the edge detector's history flop
    s_d.ext0_meta = ext0_pin;
    s_d.ext0_sync = s_q.ext0_meta;
    s_d.ext0_prev = s_q.ext0_sync;

    // Read data stands in the cycle after the strobe only
    s_d.rdata = reg_rd ? rd_val : '0;

    // Software writes; hardware sets are applied afterwards so they win
    if (reg_wr)
    begin
      if (reg_addr == IDX_GCTRL1)
      begin
        s_d.nest_dis   = reg_wdata[GC1_NEST_BIT];
        s_d.trap_flags = reg_wdata[GC1_TRAP_LSB +: NUM_TRAPS];
      end
      else if (reg_addr == IDX_GCTRL2)
      begin
        s_d.alt_table     = reg_wdata[GC2_ALT_BIT];
        s_d.ext0_neg_edge = reg_wdata[GC2_EDGE_BIT];
      end
      else if (reg_addr >= IDX_FLAG0 && reg_addr < IDX_FLAG0 + ADDR_W'(NUM_FREGS))
      begin
        s_d.flags[(reg_addr - IDX_FLAG0)*DATA_W +: DATA_W] = reg_wdata;
      end
      else if (reg_addr >= IDX_EN0 && reg_addr < IDX_EN0 + ADDR_W'(NUM_FREGS))
      begin
        s_d.enables[(reg_addr - IDX_EN0)*DATA_W +: DATA_W] = reg_wdata;
      end
      else if (reg_addr >= IDX_PRIO0 && reg_addr < IDX_PRIO0 + ADDR_W'(NUM_PREGS))
      begin
        for (int unsigned k = 0; k < FLD_PER_PR; k++)
        begin
          s_d.prios[((reg_addr - IDX_PRIO0)*FLD_PER_PR + k)*PRIO_W +: PRIO_W] =
            reg_wdata[k*4 +: PRIO_W];
        end
      end
      else if (reg_addr == IDX_STATUS)
      begin
        s_d.cpu_level[PRIO_W-1:0] = reg_wdata[SR_IPL_LSB +: PRIO_W];
      end
      // The core control word is read-only here: the top level bit cannot be
      // raised by software, so traps can never be masked
    end

    // Hardware sets win over a clearing write in the same cycle
    s_d.flags      = s_d.flags | hw_set;
    s_d.trap_flags = s_d.trap_flags | trap_evt;

    // Core handshake; acknowledge and return take over a status write
    if (irq_ack)
    begin
      s_d.cpu_level = s_q.lvl;
      s_d.depth     = s_q.depth + LVL_W'(1);
    end
    else if (irq_return)
    begin
      s_d.cpu_level = ret_level;
      s_d.depth     = (s_q.depth != '0) ? s_q.depth - LVL_W'(1) : s_q.depth;
    end
    if (trap_evt != '0)
    begin
      s_d.cpu_level[LVL_W-1] = 1'b1;
    end

    // Latch winner, its level and its table entry
    s_d.irq_req = (best_prio != PRIO_OFF) && !blocked && !irq_ack;
    if (best_prio != PRIO_OFF)
    begin
      s_d.vec   = best_vec;
      s_d.lvl   = {1'b0, best_prio};
      s_d.vaddr = vec_addr(best_vec, s_q.alt_table);
    end
  end

  // ==========================================================================
  // State register with synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      s_q               <= '0;
      s_q.prios         <= {(NUM_SRC){PRIO_RESET}};
      s_q.vaddr         <= IVT_BASE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs straight from flops
  assign reg_rdata  = s_q.rdata;
  assign irq_req    = s_q.irq_req;
  assign irq_vector = s_q.vec;
  assign irq_level  = s_q.lvl;
  assign irq_addr   = s_q.vaddr;
  assign cpu_level  = s_q.cpu_level;

endmodule : vpi_ctrl

`default_nettype wire

// ### shared/vpi_pkg.sv
// Constants and the state type of the vectored priority interrupt controller.
// Assumes a 16-bit register port indexed by word and a single 200 MHz clock.
`default_nettype none

package vpi_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned ADDR_W     = 6;
  localparam int unsigned DATA_W     = 16;
  localparam int unsigned NUM_SRC    = 96;
  localparam int unsigned PRIO_W     = 3;
  localparam int unsigned VEC_W      = 7;
  localparam int unsigned LVL_W      = 4;
  localparam int unsigned VADDR_W    = 24;
  localparam int unsigned NUM_TRAPS  = 4;
  localparam int unsigned NUM_FREGS  = 6;
  localparam int unsigned NUM_PREGS  = 24;
  localparam int unsigned FLD_PER_PR = 4;

  // ==========================================================================
  // Register indices (word addresses)
  localparam logic [ADDR_W-1:0] IDX_GCTRL1 = 6'h00;
  localparam logic [ADDR_W-1:0] IDX_GCTRL2 = 6'h01;
  localparam logic [ADDR_W-1:0] IDX_FLAG0  = 6'h02;
  localparam logic [ADDR_W-1:0] IDX_EN0    = 6'h08;
  localparam logic [ADDR_W-1:0] IDX_PRIO0  = 6'h0e;
  localparam logic [ADDR_W-1:0] IDX_LATCH  = 6'h26;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 6'h27;
  localparam logic [ADDR_W-1:0] IDX_CORE   = 6'h28;
  localparam int unsigned       PREG_GAP_A = 14;
  localparam int unsigned       PREG_GAP_B = 17;

  // ==========================================================================
  // Field positions
  localparam int unsigned GC1_NEST_BIT  = 15;
  localparam int unsigned GC1_TRAP_LSB  = 1;
  localparam int unsigned GC2_ALT_BIT   = 15;
  localparam int unsigned GC2_EDGE_BIT  = 0;
  localparam int unsigned LATCH_VEC_LSB = 0;
  localparam int unsigned LATCH_LVL_LSB = 8;
  localparam int unsigned SR_IPL_LSB    = 5;
  localparam int unsigned CORE_TOP_BIT  = 3;

  // ==========================================================================
  // Reset values and vector table layout
  localparam logic [PRIO_W-1:0]  PRIO_RESET  = 3'h4;
  localparam logic [PRIO_W-1:0]  PRIO_OFF    = 3'h0;
  localparam logic [VADDR_W-1:0] IVT_BASE    = 24'h000014;
  localparam logic [VADDR_W-1:0] ALTERNATE_VECTOR_TABLE_OFFSET = 24'h000100;

  // Sources without a priority field: holes at priority registers 14 and 17,
  // and the low field of priority registers 6 and 20
  localparam logic [NUM_SRC-1:0] SRC_IMPL =
    ~((96'hf << 56) | (96'hf << 68) | (96'h1 << 24) | (96'h1 << 80));

  // ==========================================================================
  // Whole state of the controller
  typedef struct packed {
    logic                        nest_dis;
    logic [NUM_TRAPS-1:0]        trap_flags;
    logic                        alt_table;
    logic                        ext0_neg_edge;
    logic [NUM_SRC-1:0]          flags;
    logic [NUM_SRC-1:0]          enables;
    logic [NUM_SRC*PRIO_W-1:0]   prios;
    logic [LVL_W-1:0]            cpu_level;
    logic [LVL_W-1:0]            depth;
    logic                        ext0_meta;
    logic                        ext0_sync;
    logic                        ext0_prev;
    logic [DATA_W-1:0]           rdata;
    logic                        irq_req;
    logic [VEC_W-1:0]            vec;
    logic [LVL_W-1:0]            lvl;
    logic [VADDR_W-1:0]          vaddr;
  } vpi_state_s;

endpackage : vpi_pkg

`default_nettype wire

// ### dv/vpi_ctrl_asserts.sv
// Port-level assertions for the interrupt controller.
// Bound into vpi_ctrl; one clock domain, traps never coincide with an accept.
`timescale 1ns/1ps
`default_nettype none
module vpi_ctrl_asserts
  import vpi_pkg::*;
(
  input wire logic                        clk_sys,
  input wire logic                        sys_rst,
  input wire logic                        reg_rd,
  input wire logic [vpi_pkg::DATA_W-1:0]  reg_rdata,
  input wire logic                        irq_req,
  input wire logic [vpi_pkg::VEC_W-1:0]   irq_vector,
  input wire logic [vpi_pkg::LVL_W-1:0]   irq_level,
  input wire logic [vpi_pkg::VADDR_W-1:0] irq_addr,
  input wire logic                        irq_ack,
  input wire logic                        irq_return,
  input wire logic [vpi_pkg::LVL_W-1:0]   ret_level,
  input wire logic [vpi_pkg::LVL_W-1:0]   cpu_level
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // ==========================================================================
  // Core handshake, accept cycle
  sequence s_ack;
    irq_req && irq_ack;
  endsequence
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read cycle");
  a_ack_drops_req: assert property (s_ack |=> !irq_req)
    else $error("request stayed after accept");
  a_ack_sets_level: assert property (s_ack |=> cpu_level == $past(irq_level))
    else $error("level not taken on accept");
  a_level_in_range: assert property (irq_req |-> irq_level[3] == 1'b0 && irq_level != 0)
    else $error("presented level out of range");
  a_entry_address: assert property (irq_req |->
    (irq_addr & ~ALTERNATE_VECTOR_TABLE_OFFSET) == IVT_BASE + {irq_vector, 1'b0})
    else $error("entry address does not match vector");
  a_above_cur_level: assert property (irq_req |-> irq_level > $past(cpu_level))
    else $error("request not above current level");
  a_return_level: assert property (irq_return |=> cpu_level == $past(ret_level))
    else $error("level not restored on return");
  a_reset_state: assert property ($fell(sys_rst) |->
    !irq_req && irq_addr == IVT_BASE && cpu_level == 0)
    else $error("state after reset wrong");
endmodule : vpi_ctrl_asserts

bind vpi_ctrl vpi_ctrl_asserts u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
  .irq_addr(irq_addr), .irq_ack(irq_ack), .irq_return(irq_return), .ret_level(ret_level),
  .cpu_level(cpu_level));
`default_nettype wire

// ### dv/vpi_core_model.sv
// Processor core model: accepts a request, holds it HOLD cycles, returns.
// Assumes the controller's registered request and level outputs.
`timescale 1ns/1ps
`default_nettype none
module vpi_core_model #(
  parameter int HOLD = 40
) (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       ack_en,
  input  wire logic       irq_req,
  input  wire logic [3:0] cpu_level,
  output var  logic       irq_ack,
  output var  logic       irq_return,
  output var  logic [3:0] ret_level
);
  logic [7:0] cnt_q;
  logic       busy_q;
  // Accept only when idle, so a held request is not taken twice
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      busy_q <= 1'b0;
      ret_level <= 4'h0;
      cnt_q <= 8'h00;
    end
    else if (!busy_q && ack_en && irq_req && !irq_ack)
    begin
      irq_ack <= 1'b1;
      irq_return <= 1'b0;
      busy_q <= 1'b1;
      ret_level <= cpu_level; // Level to restore on return
      cnt_q <= 8'(HOLD);
    end
    else if (busy_q && cnt_q == 8'h00)
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b1;
      busy_q <= 1'b0;
    end
    else
    begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      if (busy_q)
        cnt_q <= cnt_q - 8'h01;
    end
  end
endmodule : vpi_core_model
`default_nettype wire

// ### dv/tb.sv
// Self-checking bench for the interrupt controller.
// Drives the register port and request pulses; core model answers.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import vpi_pkg::*;
  logic clk_sys = 1'b0;
  logic sys_rst, reg_wr, reg_rd, ack_en, irq_req, irq_ack, irq_return;
  logic [5:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [95:0] src_req;
  logic ext0_pin;
  logic [3:0] trap_evt;
  logic [6:0] irq_vector;
  logic [3:0] irq_level, ret_level, cpu_level;
  logic [23:0] irq_addr;
  int error_cnt = 0;
  int checks = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  vpi_ctrl dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .src_req(src_req), .ext0_pin(ext0_pin), .trap_evt(trap_evt), .irq_req(irq_req),
    .irq_vector(irq_vector), .irq_level(irq_level), .irq_addr(irq_addr), .irq_ack(irq_ack),
    .irq_return(irq_return), .ret_level(ret_level), .cpu_level(cpu_level));
  vpi_core_model core (.clk_sys(clk_sys), .sys_rst(sys_rst), .ack_en(ack_en),
    .irq_req(irq_req), .cpu_level(cpu_level), .irq_ack(irq_ack), .irq_return(irq_return),
    .ret_level(ret_level));
  // ==========================================================================
  // Bus and check helpers
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input string what, input logic [5:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk(what, {8'h00, exp}, {8'h00, reg_rdata});
  endtask : rd_chk
  task automatic pulse(input logic [95:0] m);
    @(posedge clk_sys);
    src_req <= m;
    @(posedge clk_sys);
    src_req <= '0;
  endtask : pulse
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle
  // Bounded wait, caller judges the outcome
  task automatic wait_req();
    int i;
    i = 0;
    while (irq_req !== 1'b1 && i < 10)
    begin
      settle(1);
      i++;
    end
  endtask : wait_req
  // ==========================================================================
  // Scenarios
  task automatic fire(input int v, input int p, input logic [15:0] pv, input int lvl,
                      input logic [23:0] addr);
    wr(6'(IDX_EN0 + v / 16), 16'(1 << (v % 16)));
    wr(6'(IDX_PRIO0 + p), pv);
    pulse(96'h1 << v);
    wait_req();
    chk("request", 24'h1, {23'h0, irq_req});
    chk("vector", 24'(v), {17'h0, irq_vector});
    chk("level", 24'(lvl), {20'h0, irq_level});
    chk("entry", addr, irq_addr);
    rd_chk("latch", IDX_LATCH, 16'((lvl << 8) | v));
    wr(6'(IDX_FLAG0 + v / 16), 16'h0000);
    wr(6'(IDX_EN0 + v / 16), 16'h0000);
    settle(3);
    chk("request off", 24'h0, {23'h0, irq_req});
    $display("test vector %0d done", v);
  endtask : fire
  task automatic t_reset();
    rd_chk("prio6", 6'(IDX_PRIO0 + 6), 16'h4440);
    rd_chk("prio20", 6'(IDX_PRIO0 + 20), 16'h4440);
    rd_chk("prio0", IDX_PRIO0, 16'h4444);
    rd_chk("hole", 6'(IDX_PRIO0 + 14), 16'h0000);
    rd_chk("unmapped", 6'h3f, 16'h0000);
    wr(IDX_CORE, 16'h0008);
    rd_chk("core", IDX_CORE, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_mask();
    pulse(96'h20);
    settle(3);
    chk("disabled", 24'h0, {23'h0, irq_req});
    rd_chk("flag0", IDX_FLAG0, 16'h0020);
    wr(6'(IDX_PRIO0 + 1), 16'h4404);
    wr(IDX_EN0, 16'h0020);
    settle(3);
    chk("prio zero", 24'h0, {23'h0, irq_req});
    wr(IDX_FLAG0, 16'h0000);
    wr(IDX_EN0, 16'h0000);
    wr(6'(IDX_PRIO0 + 1), 16'h4444);
    $display("test mask done");
  endtask : t_mask
  task automatic t_tie();
    wr(IDX_EN0, 16'h0006);
    pulse(96'h6);
    wait_req();
    chk("tie vector", 24'h1, {17'h0, irq_vector});
    wr(IDX_STATUS, 16'h0080);
    settle(3);
    chk("equal level", 24'h0, {23'h0, irq_req});
    rd_chk("status", IDX_STATUS, 16'h0080);
    wr(IDX_STATUS, 16'h0000);
    wr(IDX_FLAG0, 16'h0000);
    wr(IDX_EN0, 16'h0000);
    $display("test tie done");
  endtask : t_tie
  task automatic t_nest();
    wr(IDX_EN0, 16'h0008);
    ack_en <= 1'b1;
    pulse(96'h8);
    settle(6);
    chk("accepted level", 24'h5, {20'h0, cpu_level});
    ack_en <= 1'b0;
    wr(IDX_GCTRL1, 16'h8000);
    wr(IDX_STATUS, 16'h0040);
    settle(3);
    chk("nest blocked", 24'h0, {23'h0, irq_req});
    wr(IDX_GCTRL1, 16'h0000);
    wait_req();
    chk("nest open", 24'h1, {23'h0, irq_req});
    wr(IDX_FLAG0, 16'h0000);
    wr(IDX_EN0, 16'h0000);
    settle(40);
    rd_chk("restored", IDX_STATUS, 16'h0000);
    $display("test nest done");
  endtask : t_nest
  // External pin edge on vector zero, then a trap raising the top level bit
  task automatic t_pins();
    wr(IDX_EN0, 16'h0001);
    @(posedge clk_sys);
    ext0_pin <= 1'b1;
    wait_req();
    chk("ext0 request", 24'h1, {23'h0, irq_req});
    chk("ext0 vector", 24'h0, {17'h0, irq_vector});
    ext0_pin <= 1'b0;
    wr(IDX_FLAG0, 16'h0000);
    wr(IDX_EN0, 16'h0000);
    @(posedge clk_sys);
    trap_evt <= 4'h1;
    @(posedge clk_sys);
    trap_evt <= 4'h0;
    settle(1);
    chk("trap level", 24'h8, {20'h0, cpu_level});
    rd_chk("trap flag", IDX_GCTRL1, 16'h0002);
    rd_chk("core top", IDX_CORE, 16'h0008);
    wr(IDX_GCTRL1, 16'h0000);
    rd_chk("trap clear", IDX_GCTRL1, 16'h0000);
    $display("test pins done");
  endtask : t_pins
  // ==========================================================================
  // Verdict
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : tally_and_finish
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  initial
  begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    src_req = '0;
    ext0_pin = 1'b0;
    trap_evt = 4'h0;
    ack_en = 1'b0;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset();
    fire(3, 0, 16'h5444, 5, 24'h00001a);
    fire(27, 6, 16'h7440, 7, 24'h00004a);
    fire(83, 20, 16'h6440, 6, 24'h0000ba);
    fire(82, 20, 16'h4340, 3, 24'h0000b8);
    fire(81, 20, 16'h4420, 2, 24'h0000b6);
    fire(86, 21, 16'h4144, 1, 24'h0000c0);
    wr(IDX_GCTRL2, 16'h8000);
    fire(3, 0, 16'h5444, 5, 24'h00011a);
    fire(86, 21, 16'h4144, 1, 24'h0001c0);
    wr(IDX_GCTRL2, 16'h0000);
    t_mask();
    t_tie();
    t_nest();
    t_pins();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
